// ---- hw/hics_params.svh ----
// Constants for the host command query handler
// How it works
// R1: The region-code read (command field 0x0007, no parameters) answers with status then one region byte.
// R2: Every answer starts with a status byte, 0x00 for success and 0x01 to 0xFF for an error code.
// R3: Region codes are 0x00 default band, 0x01 France, 0x02 Spain, 0x03 Japan, and 0x04 to 0xFF are reserved.
// R4: The address read (command field 0x0009) answers with status then the 48-bit address in six bytes.
// R5: Each finished command raises a command-complete event unless the host has masked it.
// R6: The status group is selected by group field 0x05, which the host encodes and the device decodes.
// R7: Only the controller changes status values, and host writes are refused except the tally reset.
// R8: The tally read (command field 0x0001, one handle) answers with status, handle and that tally.
// R9: A flush after the remote side stayed silent past the flush timeout adds one to that tally.
// R10: The tally clears on a new connection, on an ack while it is non-zero, and on the reset command; an ack in the same cycle as a flush is ignored.
// R11: A handle travels in two bytes with 12 meaningful bits, 0x000 to 0xEFF valid and 0xF00 up reserved.
// R12: The host names only the handle of an asynchronous data connection in tally commands.
// R13: The returned tally is two bytes holding the consecutive failed contacts of that connection.
// R14: The tally reset (command field 0x0002) takes a handle and answers with status and the same handle.
// R15: A tally saturates at its maximum, and an unknown or reserved handle gets a non-zero status.
`ifndef HICS_PARAMS_SVH
`define HICS_PARAMS_SVH
`define HICS_OGF_INFO        6'h04
`define HICS_OGF_STATUS      6'h05
`define HICS_OCF_REGION      10'h007
`define HICS_OCF_ADDR        10'h009
`define HICS_OCF_TALLY_RD    10'h001
`define HICS_OCF_TALLY_RST   10'h002
`define HICS_ST_OK           8'h00
`define HICS_ST_UNKNOWN_CMD  8'h01
`define HICS_ST_NO_CONN      8'h02
`define HICS_ST_BAD_PARAM    8'h12
`define HICS_HANDLE_MAX      12'hEFF
`define HICS_REGION_MAX      8'h03
`define HICS_REGION_RESET    8'h00
`endif

// ---- hw/hics_pkg.sv ----
// Types for the host command query handler
package hics_pkg;
  typedef struct packed {
    logic [5:0]  group;
    logic [9:0]  command;
    logic [15:0] handle;
  } hics_cmd_t;
  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  nbytes;
    logic [15:0] opcode;
    logic [63:0] payload;
  } hics_rsp_t;
endpackage

// ---- hw/hics_tally.sv ----
// Per-connection missed-contact tally store
`timescale 1ns/1ps
`include "hics_params.svh"
module hics_tally import hics_pkg::*; #(
  parameter int SLOTS = 4,
  parameter int TW    = 16
) (
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire logic [SLOTS-1:0]         open_evt,
  input  wire logic [SLOTS-1:0]         flush_evt,
  input  wire logic [SLOTS-1:0]         ack_evt,
  input  wire logic [SLOTS-1:0]         host_clr,
  output logic      [SLOTS-1:0][TW-1:0] tally
);
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : gen_slot
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          tally[g] <= '0;
        end else if (open_evt[g] || host_clr[g]) begin
          tally[g] <= '0; // [R10]
        end else if (flush_evt[g]) begin
          if (tally[g] != {TW{1'b1}}) begin
            tally[g] <= tally[g] + 1'b1; // [R9] [R15]
          end
        end else if (ack_evt[g] && tally[g] != '0) begin
          tally[g] <= '0; // [R10]
        end
      end
    end
  endgenerate
endmodule

// ---- hw/hics_top.sv ----
// Command handler for region, address and missed-contact tally queries
`timescale 1ns/1ps
`include "hics_params.svh"
module hics_top import hics_pkg::*; #(
  parameter int          SLOTS = 4,
  parameter logic [47:0] DEV_ADDR = 48'h0000_0000_0001, // arbitrary value
  parameter logic [7:0]  REGION = `HICS_REGION_RESET
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              cmd_valid,
  input  wire hics_cmd_t         cmd,
  input  wire logic              complete_mask,
  input  wire logic [SLOTS-1:0]  conn_open,
  input  wire logic [SLOTS-1:0]  conn_active,
  input  wire logic [SLOTS-1:0][11:0] conn_handle,
  input  wire logic [SLOTS-1:0]  flush_timeout,
  input  wire logic [SLOTS-1:0]  pkt_acked,
  output logic                   rsp_valid,
  output hics_rsp_t              rsp,
  output logic                   complete_evt
);
  logic [SLOTS-1:0][15:0] tally;
  logic [SLOTS-1:0]       host_clr;
  logic [SLOTS-1:0]       next_host_clr;
  hics_rsp_t              next_rsp;
  logic                   hit;
  logic [15:0]            hit_tally;
  logic [15:0]            h16;

  hics_tally #(.SLOTS(SLOTS), .TW(16)) u_tally (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .open_evt  (conn_open),
    .flush_evt (flush_timeout),
    .ack_evt   (pkt_acked),
    .host_clr  (host_clr),
    .tally     (tally)
  );

  // Handle lookup among open data connections
  always_comb begin
    hit = 1'b0;
    hit_tally = '0;
    next_host_clr = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (conn_active[i] && conn_handle[i] == cmd.handle[11:0]) begin
        hit = 1'b1;
        hit_tally = tally[i];
        // Reserved handles alias a slot in the low 12 bits, so they must not clear it
        next_host_clr[i] = cmd_valid && cmd.group == `HICS_OGF_STATUS
                           && cmd.command == `HICS_OCF_TALLY_RST
                           && cmd.handle <= {4'h0, `HICS_HANDLE_MAX}; // [R7] [R10] [R11]
      end
    end
  end

  always_comb begin
    h16 = {4'h0, cmd.handle[11:0]}; // [R11]
    next_rsp = '0;
    next_rsp.opcode = {cmd.group, cmd.command};
    next_rsp.status = `HICS_ST_UNKNOWN_CMD; // [R2] [R7]
    next_rsp.nbytes = 8'h01;
    if (cmd.group == `HICS_OGF_INFO && cmd.command == `HICS_OCF_REGION) begin
      next_rsp.status = `HICS_ST_OK;
      next_rsp.nbytes = 8'h02;
      next_rsp.payload = {56'h0, REGION}; // [R1] [R3]
    end else if (cmd.group == `HICS_OGF_INFO && cmd.command == `HICS_OCF_ADDR) begin
      next_rsp.status = `HICS_ST_OK;
      next_rsp.nbytes = 8'h07;
      next_rsp.payload = {16'h0, DEV_ADDR}; // [R4]
    end else if (cmd.group == `HICS_OGF_STATUS && // [R6]
                 (cmd.command == `HICS_OCF_TALLY_RD || cmd.command == `HICS_OCF_TALLY_RST)) begin
      next_rsp.nbytes = 8'h03;
      next_rsp.payload = {48'h0, h16}; // [R14]
      if (cmd.handle > {4'h0, `HICS_HANDLE_MAX}) begin
        next_rsp.status = `HICS_ST_BAD_PARAM; // [R11] [R15]
      end else if (!hit) begin
        next_rsp.status = `HICS_ST_NO_CONN; // [R12] [R15]
      end else begin
        next_rsp.status = `HICS_ST_OK;
        if (cmd.command == `HICS_OCF_TALLY_RD) begin
          next_rsp.nbytes = 8'h05;
          next_rsp.payload = {32'h0, hit_tally, h16}; // [R8] [R13]
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      host_clr <= '0;
    end else begin
      host_clr <= next_host_clr;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      complete_evt <= 1'b0;
    end else begin
      rsp_valid <= cmd_valid;
      complete_evt <= cmd_valid && !complete_mask; // [R5]
      if (cmd_valid) begin
        rsp <= next_rsp;
      end
    end
  end
endmodule

// ---- tb/hics_host.sv ----
// Host model issuing one command per request
`timescale 1ns/1ps
module hics_host import hics_pkg::*; (
  input  wire logic      mclk,
  input  wire logic      go,
  input  wire hics_cmd_t next_cmd,
  output logic           cmd_valid,
  output hics_cmd_t      cmd
);
  always_ff @(posedge mclk) begin
    cmd_valid <= go;
    cmd       <= next_cmd;
  end
endmodule

// ---- tb/hics_monitor.sv ----
// Checker of command answers
`timescale 1ns/1ps
module hics_monitor import hics_pkg::*; (
  input wire logic      mclk,
  input wire logic      reset_n,
  input wire logic      cmd_valid,
  input wire hics_cmd_t cmd,
  input wire logic      rsp_valid,
  input wire hics_rsp_t rsp,
  input wire logic      complete_mask,
  input wire logic      complete_evt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_q(g, c); cmd_valid && cmd.group == g && cmd.command == c; endsequence
  property p_ans; cmd_valid |=> rsp_valid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_evt; cmd_valid |=> complete_evt == !$past(complete_mask); endproperty
  a_evt: assert property (p_evt) else $error("bad complete event");
  property p_ops; cmd_valid |=> rsp.opcode == {$past(cmd.group), $past(cmd.command)}; endproperty
  a_ops: assert property (p_ops) else $error("bad opcode");
  property p_reg; s_q(6'h04, 10'h007) |=> rsp.status == 8'h00 && rsp.nbytes == 8'h02 && rsp.payload[7:0] <= 8'h03; endproperty
  a_reg: assert property (p_reg) else $error("bad region");
  property p_adr; s_q(6'h04, 10'h009) |=> rsp.status == 8'h00 && rsp.nbytes == 8'h07; endproperty
  a_adr: assert property (p_adr) else $error("bad address");
  property p_rd; s_q(6'h05, 10'h001) ##1 rsp.status == 8'h00 |-> rsp.nbytes == 8'h05 && rsp.payload[15:0] == $past(cmd.handle); endproperty
  a_rd: assert property (p_rd) else $error("bad tally read");
  property p_rst; s_q(6'h05, 10'h002) ##1 rsp.status == 8'h00 |-> rsp.nbytes == 8'h03 && rsp.payload[15:0] == $past(cmd.handle); endproperty
  a_rst: assert property (p_rst) else $error("bad tally reset");
  property p_res; s_q(6'h05, 10'h001) ##0 cmd.handle > 16'h0EFF |=> rsp.status == 8'h12; endproperty
  a_res: assert property (p_res) else $error("reserved handle taken");
  property p_unk; cmd_valid && cmd.group == 6'h05 && cmd.command > 10'h002 |=> rsp.status == 8'h01 && rsp.nbytes == 8'h01; endproperty
  a_unk: assert property (p_unk) else $error("unknown command taken");
endmodule

// ---- tb/hics_top_tb.sv ----
// Testbench of the command handler
`timescale 1ns/1ps
module hics_top_tb;
  import hics_pkg::*;
  logic             mclk = 0, reset_n = 0, go = 0, complete_mask = 0, rsp_valid, complete_evt, cmd_valid;
  logic [3:0]       conn_open = 0, flush_timeout = 0, pkt_acked = 0, conn_active = 4'h3;
  logic [3:0][11:0] conn_handle = {12'h055, 12'h000, 12'h123, 12'h00A};
  hics_cmd_t        next_cmd = 0, cmd;
  hics_rsp_t        rsp;
  int               fail_count = 0, compares = 0;
  logic [79:0]      rows [8] = '{80'h1007_0000_00_02_0000_0000, 80'h1009_0000_00_07_0000_0001,
    80'h1401_000A_00_05_0000_000A, 80'h1402_0123_00_03_0000_0123, 80'h1401_0055_02_00_0000_0000,
    80'h1401_0F00_12_00_0000_0000, 80'h1403_0000_01_00_0000_0000, 80'h0C07_0000_01_00_0000_0000};
  always #2.5 mclk = ~mclk;
  hics_host host (.mclk, .go, .next_cmd, .cmd_valid, .cmd);
  hics_top dut (.mclk, .reset_n, .cmd_valid, .cmd, .complete_mask, .conn_open, .conn_active, .conn_handle,
    .flush_timeout, .pkt_acked, .rsp_valid, .rsp, .complete_evt);
  task automatic chk(input logic [47:0] g, e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic run(input logic [79:0] r);
    @(posedge mclk);
    go <= 1;
    next_cmd <= r[79:48];
    @(posedge mclk) go <= 0;
    @(posedge mclk);
    @(negedge mclk) chk({rsp_valid, complete_evt}, {1'b1, !complete_mask});
    if (r[47:40] == 0) chk({rsp.status, rsp.nbytes, rsp.payload[31:0]}, r[47:0]);
    else chk(rsp.status, r[47:40]);
  endtask
  task automatic test_done;
    $display("errors %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1;
    @(posedge mclk) conn_open <= 4'h3;
    @(posedge mclk) conn_open <= 0;
    foreach (rows[i]) run(rows[i]);
    @(posedge mclk) flush_timeout <= 4'h1;
    repeat (3) @(posedge mclk);
    flush_timeout <= 0;
    run(80'h1401_000A_00_05_0003_000A);
    @(posedge mclk) pkt_acked <= 4'h1;
    @(posedge mclk) pkt_acked <= 0;
    run(80'h1401_000A_00_05_0000_000A);
    @(posedge mclk) flush_timeout <= 4'h1;
    repeat (2) @(posedge mclk);
    flush_timeout <= 0;
    run(rows[3] ^ 80'h0000_0129_00_00_0000_0129);
    run(80'h1401_000A_00_05_0000_000A);
    @(posedge mclk) complete_mask <= 1;
    run(rows[0]);
    @(posedge mclk) complete_mask <= 0;
    conn_active <= 4'h1;
    run(80'h1401_0123_02_00_0000_0000);
    @(posedge mclk) conn_active <= 4'h3;
    flush_timeout <= 4'h1;
    repeat (65540) @(posedge mclk);
    flush_timeout <= 0;
    run(80'h1401_000A_00_05_FFFF_000A);
    @(posedge mclk) reset_n <= 0;
    @(negedge mclk) chk({rsp_valid, complete_evt}, 48'h0);
    @(posedge mclk) reset_n <= 1;
    run(80'h1401_000A_00_05_0000_000A);
    test_done;
  end
  initial begin
    repeat (80000) @(posedge mclk);
    fail_count++;
    test_done;
  end
endmodule
bind hics_top hics_monitor mon (.*);
